// File: verilog/iop_pkg.sv
// Purpose: shared constants for the I/O board configuration register bank
// Assumes: 16-bit register numbers and 16-bit register data
// Notes:   offsets are register numbers, not byte addresses
package iop_pkg;

  // ==========================================================================
  // widths and bus identity
  // ==========================================================================
  localparam int          REG_W      = 16;
  localparam int          CNT_W      = 32;
  localparam logic [7:0]  SLAVE_ADDR = 8'hc8;

  // ==========================================================================
  // register numbers
  // ==========================================================================
  localparam logic [15:0] A_SP1_OUT   = 16'h01f9;
  localparam logic [15:0] A_SP2_OUT   = 16'h01fa;
  localparam logic [15:0] A_SP1_EN    = 16'h0899;
  localparam logic [15:0] A_SP2_EN    = 16'h08cb;
  localparam logic [15:0] A_SP1_VOLT  = 16'h0e11;
  localparam logic [15:0] A_SP1_CONT  = 16'h0e12;
  localparam logic [15:0] A_SP2_VOLT  = 16'h0e25;
  localparam logic [15:0] A_SP2_CONT  = 16'h0e26;
  localparam logic [15:0] A_CHG_ALGO  = 16'h17b7;
  localparam logic [15:0] A_BATT_MV   = 16'h17c1;
  localparam logic [15:0] A_CHG_MA    = 16'h17c2;
  localparam logic [15:0] A_SUPPLY_MV = 16'h17c3;
  localparam logic [15:0] A_BRD_TEMP  = 16'h17c4;
  localparam logic [15:0] A_IN_KIND   = 16'h0bb9;
  localparam logic [15:0] A_TEMP_UNIT = 16'h0bba;
  localparam logic [15:0] A_FULL_SCL  = 16'h0bbb;
  localparam logic [15:0] A_THRESH    = 16'h0bbc;
  localparam logic [15:0] A_HYST      = 16'h0bbd;
  localparam logic [15:0] A_RISE_EN   = 16'h0bbe;
  localparam logic [15:0] A_FALL_EN   = 16'h0bbf;
  localparam logic [15:0] A_CNT_HIGH  = 16'h0bc0;
  localparam logic [15:0] A_CNT_LOW   = 16'h0bc1;
  localparam logic [15:0] A_READING   = 16'h0bc2;

  // ==========================================================================
  // values after reset
  // ==========================================================================
  localparam logic [15:0] RST_SP_EN   = 16'h0001;
  localparam logic [15:0] RST_SP_VOLT = 16'h0000;
  localparam logic [15:0] RST_SP_CONT = 16'h0000;
  localparam logic [15:0] RST_SP_OUT  = 16'h0000;
  localparam logic [15:0] RST_ALGO    = 16'h0001;
  localparam logic [15:0] RST_KIND    = 16'h0008;
  localparam logic [15:0] RST_UNIT    = 16'h0000;
  localparam logic [15:0] RST_ZERO    = 16'h0000;

  // ==========================================================================
  // input kinds and scaling
  // ==========================================================================
  localparam logic [15:0] KIND_NPN     = 16'h0000;
  localparam logic [15:0] KIND_PNP     = 16'h0001;
  localparam logic [15:0] KIND_CURRENT = 16'h0002;
  localparam logic [15:0] KIND_VOLTAGE = 16'h0003;
  localparam logic [15:0] KIND_THERM   = 16'h0004;
  localparam logic [15:0] KIND_POT     = 16'h0005;
  localparam logic [15:0] KIND_BRIDGE  = 16'h0007;
  localparam logic [15:0] KIND_NPN_RAW = 16'h0008;
  localparam logic [15:0] FS_TOP       = 16'hffff;
  localparam logic [15:0] SPAN_UA      = 16'd20000;
  localparam logic [15:0] SPAN_MV      = 16'd10000;
  // reciprocal factors, rounded up so the span top reaches the full-scale top
  // the millivolt factor needs 19 bits, so both are held at 20
  localparam logic [19:0] FS_K_UA = 20'((64'd65535 * 64'd65536 + 64'd19999) / 64'd20000);
  localparam logic [19:0] FS_K_MV = 20'((64'd65535 * 64'd65536 + 64'd9999) / 64'd10000);
  localparam logic [15:0] NO_BATT_MV   = 16'd5000;
  localparam logic [19:0] F_OFFSET_X10 = 20'd320;

endpackage : iop_pkg

// File: verilog/iop_pin_sync.sv
// Purpose: brings an outside pin level into the i_mclk domain
// Assumes: pin changes are slow next to the 20 ns clock
// Notes:   a change is taken once the second and third stages agree
`timescale 1ns/1ps
module iop_pin_sync (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level
);
  import iop_pkg::*;

  logic meta;
  logic stage2;
  logic stage3;

  // ==========================================================================
  // three stages, agreement filter
  // ==========================================================================
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta    <= 1'b0;
      stage2  <= 1'b0;
      stage3  <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta   <= i_pin;
      stage2 <= meta;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        o_level <= stage3;
      end
    end
  end

endmodule : iop_pin_sync

// File: verilog/iop_regs.sv
// Purpose: configuration and status register bank of the I/O board
// Assumes: requests arrive as decoded register reads and writes, one cycle each
// Notes:   answers one cycle after the request; other slave addresses are ignored
//
// Functional notes
// - full-scale on maps the current and voltage input ranges linearly onto 0 to 65535
// - full-scale off reports microamps for current and millivolts for voltage
// - counter advances on rising or falling edges only when that edge is enabled
// - counter is 32 bits over high and low registers; zeros clear it
// - a write to either counter register presets that half
// - analog input turns on once the reading reaches the threshold
// - an on input turns off once below threshold by at least the hysteresis
// - input kind codes 0 to 8, reset value 8
// - temperature unit bit selects Fahrenheit at 1, Celsius at 0 by default
// - charge algorithm 0 solar, 1 from 12 to 30 V supply, reset 1
// - read-only battery mV, charge mA, supply mV and board temperature
// - battery reading under 5 V means no battery attached
// - charge only while supply reading exceeds battery reading
// - battery powers the system while supply reading is below battery reading
// - board temperature held in tenths of a degree Celsius, uncalibrated
// - registers answer at slave address 200 only
// - output register 1 turns its switched output on, 0 turns it off
// - enable register 0 disables, 1 enables, reset enabled
// - voltage register 0 selects 5 V, 1 selects 16 V, reset 5 V
// - continuous-power value 1 applies after the next power cycle, reset 0
// - both outputs on with different voltages give 5 V or the lower one
`timescale 1ns/1ps
module iop_regs #(
  parameter bit SECOND_VARIANT = 1'b0
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  input  wire logic [7:0]            i_slave_addr,
  input  wire logic                  i_req_wr,
  input  wire logic                  i_req_rd,
  input  wire logic [15:0]           i_req_reg,
  input  wire logic [15:0]           i_req_data,
  output logic                       o_rsp_valid,
  output logic [15:0]                o_rsp_data,
  output logic                       o_rsp_exception,
  input  wire logic                  i_count_pin,
  input  wire logic                  i_sample_valid,
  input  wire logic [15:0]           i_sample,
  input  wire logic [15:0]           i_battery_mv,
  input  wire logic [15:0]           i_charge_ma,
  input  wire logic [15:0]           i_supply_mv,
  input  wire logic [15:0]           i_board_temp,
  input  wire logic                  i_power_up,
  output logic [15:0]                o_reading,
  output logic                       o_input_on,
  output logic [iop_pkg::CNT_W-1:0]  o_count,
  output logic                       o_pwr1_on,
  output logic                       o_pwr2_on,
  output logic                       o_pwr1_16v,
  output logic                       o_pwr2_16v,
  output logic                       o_charge_enable,
  output logic                       o_battery_powers,
  output logic                       o_battery_absent,
  output logic                       o_charge_from_supply
);
  import iop_pkg::*;

  // ==========================================================================
  // registers
  // ==========================================================================
  logic [15:0] sp1_out;
  logic [15:0] sp2_out;
  logic [15:0] sp1_en;
  logic [15:0] sp2_en;
  logic [15:0] sp1_volt;
  logic [15:0] sp2_volt;
  logic [15:0] sp1_cont;
  logic [15:0] sp2_cont;
  logic [15:0] chg_algo;
  logic [15:0] in_kind;
  logic [15:0] temp_unit;
  logic [15:0] full_scale;
  logic [15:0] thresh;
  logic [15:0] hyst;
  logic [15:0] rise_en;
  logic [15:0] fall_en;
  logic        cont1_applied;
  logic        cont2_applied;
  logic        pin_prev;
  logic        pin_level;

  // ==========================================================================
  // request decode
  // ==========================================================================
  wire        addr_ok = (i_slave_addr == SLAVE_ADDR);
  wire        wr      = i_req_wr & addr_ok;
  wire        rd      = i_req_rd & addr_ok & ~i_req_wr;
  wire        wr_sp1_out  = wr & (i_req_reg == A_SP1_OUT);
  wire        wr_sp2_out  = wr & (i_req_reg == A_SP2_OUT);
  wire        wr_sp1_en   = wr & (i_req_reg == A_SP1_EN);
  wire        wr_sp2_en   = wr & (i_req_reg == A_SP2_EN);
  wire        wr_sp1_volt = wr & (i_req_reg == A_SP1_VOLT);
  wire        wr_sp2_volt = wr & (i_req_reg == A_SP2_VOLT);
  wire        wr_sp1_cont = wr & (i_req_reg == A_SP1_CONT);
  wire        wr_sp2_cont = wr & (i_req_reg == A_SP2_CONT);
  wire        wr_algo     = wr & (i_req_reg == A_CHG_ALGO);
  wire        wr_kind     = wr & (i_req_reg == A_IN_KIND);
  wire        wr_unit     = wr & (i_req_reg == A_TEMP_UNIT);
  wire        wr_fs       = wr & (i_req_reg == A_FULL_SCL);
  wire        wr_thresh   = wr & (i_req_reg == A_THRESH);
  wire        wr_hyst     = wr & (i_req_reg == A_HYST);
  wire        wr_rise     = wr & (i_req_reg == A_RISE_EN);
  wire        wr_fall     = wr & (i_req_reg == A_FALL_EN);
  wire        wr_cnt_hi   = wr & (i_req_reg == A_CNT_HIGH);
  wire        wr_cnt_lo   = wr & (i_req_reg == A_CNT_LOW);
  wire        wr_known    = wr_sp1_out | wr_sp2_out | wr_sp1_en | wr_sp2_en | wr_sp1_volt | wr_sp2_volt
                          | wr_sp1_cont | wr_sp2_cont | wr_algo | wr_kind | wr_unit | wr_fs | wr_thresh
                          | wr_hyst | wr_rise | wr_fall | wr_cnt_hi | wr_cnt_lo;

  // ==========================================================================
  // read selection
  // ==========================================================================
  logic [15:0] rd_data;
  logic        rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = RST_ZERO;
    case (i_req_reg)
      A_SP1_OUT:   rd_data = sp1_out;
      A_SP2_OUT:   rd_data = sp2_out;
      A_SP1_EN:    rd_data = sp1_en;
      A_SP2_EN:    rd_data = sp2_en;
      A_SP1_VOLT:  rd_data = sp1_volt;
      A_SP2_VOLT:  rd_data = sp2_volt;
      A_SP1_CONT:  rd_data = sp1_cont;
      A_SP2_CONT:  rd_data = sp2_cont;
      A_CHG_ALGO:  rd_data = chg_algo;
      A_BATT_MV:   rd_data = i_battery_mv;
      A_CHG_MA:    rd_data = i_charge_ma;
      A_SUPPLY_MV: rd_data = i_supply_mv;
      A_BRD_TEMP:  rd_data = i_board_temp;
      A_IN_KIND:   rd_data = in_kind;
      A_TEMP_UNIT: rd_data = temp_unit;
      A_FULL_SCL:  rd_data = full_scale;
      A_THRESH:    rd_data = thresh;
      A_HYST:      rd_data = hyst;
      A_RISE_EN:   rd_data = rise_en;
      A_FALL_EN:   rd_data = fall_en;
      A_CNT_HIGH:  rd_data = o_count[31:16];
      A_CNT_LOW:   rd_data = o_count[15:0];
      A_READING:   rd_data = o_reading;
      default:     rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid     <= 1'b0;
      o_rsp_data      <= RST_ZERO;
      o_rsp_exception <= 1'b0;
    end else begin
      o_rsp_valid     <= wr | rd;
      o_rsp_data      <= rd ? rd_data : (wr ? i_req_data : RST_ZERO);
      o_rsp_exception <= (rd & ~rd_hit) | (wr & ~wr_known);
    end
  end

  // ==========================================================================
  // configuration registers
  // ==========================================================================
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp1_out    <= RST_SP_OUT;
      sp2_out    <= RST_SP_OUT;
      sp1_en     <= RST_SP_EN;
      sp2_en     <= RST_SP_EN;
      sp1_volt   <= RST_SP_VOLT;
      sp2_volt   <= RST_SP_VOLT;
      sp1_cont   <= RST_SP_CONT;
      sp2_cont   <= RST_SP_CONT;
      chg_algo   <= RST_ALGO;
      in_kind    <= RST_KIND;
      temp_unit  <= RST_UNIT;
      full_scale <= RST_ZERO;
      thresh     <= RST_ZERO;
      hyst       <= RST_ZERO;
      rise_en    <= RST_ZERO;
      fall_en    <= RST_ZERO;
    end else begin
      if (wr_sp1_out)  sp1_out    <= i_req_data;
      if (wr_sp2_out)  sp2_out    <= i_req_data;
      if (wr_sp1_en)   sp1_en     <= i_req_data;
      if (wr_sp2_en)   sp2_en     <= i_req_data;
      if (wr_sp1_volt) sp1_volt   <= i_req_data;
      if (wr_sp2_volt) sp2_volt   <= i_req_data;
      if (wr_sp1_cont) sp1_cont   <= i_req_data;
      if (wr_sp2_cont) sp2_cont   <= i_req_data;
      if (wr_algo)     chg_algo   <= i_req_data;
      if (wr_kind)     in_kind    <= i_req_data;
      if (wr_unit)     temp_unit  <= i_req_data;
      if (wr_fs)       full_scale <= i_req_data;
      if (wr_thresh)   thresh     <= i_req_data;
      if (wr_hyst)     hyst       <= i_req_data;
      if (wr_rise)     rise_en    <= i_req_data;
      if (wr_fall)     fall_en    <= i_req_data;
    end
  end

  // ==========================================================================
  // input scaling
  // ==========================================================================
  wire        kind_cur   = (in_kind == KIND_CURRENT);
  wire        kind_volt  = (in_kind == KIND_VOLTAGE);
  wire        fs_on      = full_scale[0] & (kind_cur | kind_volt);
  wire [15:0] span       = kind_cur ? SPAN_UA : SPAN_MV;
  wire [19:0] fs_k       = kind_cur ? FS_K_UA : FS_K_MV;
  wire [15:0] clamped    = (i_sample > span) ? span : i_sample;
  wire [35:0] fs_prod    = {20'h00000, clamped} * {16'h0000, fs_k};
  wire [15:0] fs_value   = (fs_prod[35:16] > {4'h0, FS_TOP}) ? FS_TOP : fs_prod[31:16];
  wire signed [19:0] c_x10 = 20'(signed'(i_sample));
  wire signed [19:0] f_x10 = 20'((c_x10 * 20'sd9) / 20'sd5) + signed'(F_OFFSET_X10);
  wire        to_fahr    = (in_kind == KIND_THERM) & temp_unit[0];
  wire [15:0] next_reading = fs_on   ? fs_value
                           : to_fahr ? f_x10[15:0]
                           : i_sample;

  // ==========================================================================
  // on/off detection
  // ==========================================================================
  wire        at_on  = (o_reading >= thresh);
  wire        at_off = ({1'b0, o_reading} + {1'b0, hyst}) <= {1'b0, thresh};

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reading  <= RST_ZERO;
      o_input_on <= 1'b0;
    end else begin
      if (i_sample_valid) begin
        o_reading <= next_reading;
      end
      if (!o_input_on && at_on) begin
        o_input_on <= 1'b1;
      end else if (o_input_on && at_off && !at_on) begin
        o_input_on <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // edge counter
  // ==========================================================================
  iop_pin_sync u_pin_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_count_pin),
    .o_level (pin_level)
  );

  wire rise_edge = pin_level & ~pin_prev & rise_en[0];
  wire fall_edge = ~pin_level & pin_prev & fall_en[0];
  wire count_hit = rise_edge | fall_edge;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_prev <= 1'b0;
      o_count  <= '0;
    end else begin
      pin_prev <= pin_level;
      if (wr_cnt_hi || wr_cnt_lo) begin
        if (wr_cnt_hi) o_count[31:16] <= i_req_data;
        if (wr_cnt_lo) o_count[15:0]  <= i_req_data;
      end else if (count_hit) begin
        o_count <= o_count + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // power monitor and switched power
  // ==========================================================================
  wire on1       = sp1_en[0] & (sp1_out[0] | cont1_applied);
  wire on2       = sp2_en[0] & (sp2_out[0] | cont2_applied);
  wire clash     = on1 & on2 & (sp1_volt[0] != sp2_volt[0]);
  wire low_pick  = SECOND_VARIANT ? (sp1_volt[0] & sp2_volt[0]) : 1'b0;
  wire next_16v1 = clash ? low_pick : sp1_volt[0];
  wire next_16v2 = clash ? low_pick : sp2_volt[0];

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cont1_applied        <= 1'b0;
      cont2_applied        <= 1'b0;
      o_pwr1_on            <= 1'b0;
      o_pwr2_on            <= 1'b0;
      o_pwr1_16v           <= 1'b0;
      o_pwr2_16v           <= 1'b0;
      o_charge_enable      <= 1'b0;
      o_battery_powers     <= 1'b0;
      o_battery_absent     <= 1'b1;
      o_charge_from_supply <= 1'b1;
    end else begin
      if (i_power_up) begin
        cont1_applied <= sp1_cont[0];
        cont2_applied <= sp2_cont[0];
      end
      o_pwr1_on            <= on1;
      o_pwr2_on            <= on2;
      o_pwr1_16v           <= next_16v1;
      o_pwr2_16v           <= next_16v2;
      o_charge_enable      <= i_supply_mv > i_battery_mv;
      o_battery_powers     <= i_supply_mv < i_battery_mv;
      o_battery_absent     <= i_battery_mv < NO_BATT_MV;
      o_charge_from_supply <= chg_algo[0];
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_fs_top;
    i_sample_valid && kind_cur && full_scale[0] && i_sample >= SPAN_UA |=> o_reading == FS_TOP;
  endproperty
  a_fs_top: assert property (p_fs_top) else $error("full scale top not 65535");

  property p_raw_units;
    i_sample_valid && !full_scale[0] && !to_fahr |=> o_reading == $past(i_sample);
  endproperty
  a_raw_units: assert property (p_raw_units) else $error("raw reading altered");

  property p_count_rise;
    !wr_cnt_hi && !wr_cnt_lo && rise_edge |=> o_count == $past(o_count) + 32'h0000_0001;
  endproperty
  a_count_rise: assert property (p_count_rise) else $error("enabled edge not counted");

  property p_count_hold;
    !wr_cnt_hi && !wr_cnt_lo && !count_hit |=> $stable(o_count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without edge");

  property p_preset_low;
    wr_cnt_lo |=> o_count[15:0] == $past(i_req_data);
  endproperty
  a_preset_low: assert property (p_preset_low) else $error("low half preset lost");

  property p_on_thresh;
    !o_input_on && o_reading >= thresh |=> o_input_on;
  endproperty
  a_on_thresh: assert property (p_on_thresh) else $error("input not on at threshold");

  property p_off_hyst;
    o_input_on && !at_off |=> o_input_on;
  endproperty
  a_off_hyst: assert property (p_off_hyst) else $error("input off inside hysteresis");

  property p_charge;
    i_supply_mv > i_battery_mv |=> o_charge_enable && !o_battery_powers;
  endproperty
  a_charge: assert property (p_charge) else $error("charge state wrong");

  property p_answer;
    (i_req_rd || i_req_wr) && i_slave_addr != SLAVE_ADDR |=> !o_rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("answered foreign address");

  property p_clash;
    clash && !SECOND_VARIANT |=> !o_pwr1_16v && !o_pwr2_16v;
  endproperty
  a_clash: assert property (p_clash) else $error("voltage clash not resolved");

  c_wrap:  cover property (o_count == 32'hffff_ffff ##1 o_count == 32'h0000_0000);
  c_onoff: cover property (o_input_on ##[1:50] !o_input_on);
  c_pwr:   cover property (o_pwr1_on && o_pwr2_on);

endmodule : iop_regs

// File: bench/iop_host_model.sv
// Purpose: modbus master host model issuing decoded register requests
// Assumes: one request per call, held for one clock
// Notes:   released register and data lines carry the inverse of the last value; read and write drop to 0
`timescale 1ns/1ps
module iop_host_model (
  input  wire logic  i_mclk,
  output logic [7:0] o_slave_addr,
  output logic       o_req_wr,
  output logic       o_req_rd,
  output logic [15:0] o_req_reg,
  output logic [15:0] o_req_data
);
  initial begin
    o_slave_addr = 8'h00;
    o_req_wr     = 1'b0;
    o_req_rd     = 1'b0;
    o_req_reg    = 16'h0000;
    o_req_data   = 16'h0000;
  end
  // ==========================================================================
  // one request, taken at the next edge
  // ==========================================================================
  task automatic req(input logic [7:0] sa, input logic wr, input logic [15:0] r, input logic [15:0] d);
    @(posedge i_mclk);
    o_slave_addr <= sa;
    o_req_wr     <= wr;
    o_req_rd     <= ~wr;
    o_req_reg    <= r;
    o_req_data   <= d;
    @(posedge i_mclk);
    o_req_wr     <= 1'b0;
    o_req_rd     <= 1'b0;
    o_req_reg    <= ~r;
    o_req_data   <= ~d;
  endtask : req
endmodule : iop_host_model

// File: bench/test_iop_regs.sv
// Purpose: self-checking bench for the register bank
// Assumes: answers one cycle after the taken edge
// Notes:   answers are checked against a queue of notes
`timescale 1ns/1ps
module test_iop_regs;
  import iop_pkg::*;
  logic        i_mclk = 1'b0, i_rst_n, i_count_pin, i_sample_valid, i_power_up, i_req_wr, i_req_rd;
  logic [7:0]  i_slave_addr;
  logic [15:0] i_req_reg, i_req_data, i_sample, o_rsp_data, o_reading;
  logic [15:0] i_battery_mv, i_charge_ma, i_supply_mv, i_board_temp;
  logic        o_rsp_valid, o_rsp_exception, o_input_on, o_pwr1_on, o_pwr2_on, o_pwr1_16v, o_pwr2_16v;
  logic        o_charge_enable, o_battery_powers, o_battery_absent, o_charge_from_supply;
  logic [31:0] o_count, seed, failures = 0, compares = 0, cycles = 0;
  logic [16:0] e;
  logic [16:0] exp_q[$];
  int          k;
  localparam logic [15:0] RA[7] = '{A_SP1_EN, A_SP2_EN, A_SP1_VOLT, A_SP2_CONT, A_CHG_ALGO, A_IN_KIND, A_TEMP_UNIT};
  localparam logic [15:0] RV[7] = '{16'h1, 16'h1, 16'h0, 16'h0, 16'h1, 16'h8, 16'h0};
  iop_regs #(.SECOND_VARIANT(1'b0)) dut_u (.*);
  iop_host_model host_u (.i_mclk(i_mclk), .o_slave_addr(i_slave_addr), .o_req_wr(i_req_wr),
    .o_req_rd(i_req_rd), .o_req_reg(i_req_reg), .o_req_data(i_req_data));
  always #10 i_mclk = ~i_mclk;
  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic report_and_stop;
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc
  task automatic acc(input logic wr, input logic [15:0] r, input logic [15:0] d, input logic [16:0] x);
    exp_q.push_back(x);
    host_u.req(SLAVE_ADDR, wr, r, d);
    cyc(2);
  endtask : acc
  task automatic pin(input logic v, input logic [31:0] want);
    @(posedge i_mclk) i_count_pin <= v;
    cyc(8);
    chk(o_count, want);
  endtask : pin
  task automatic samp(input logic [15:0] d, input logic [15:0] rd, input logic on);
    @(posedge i_mclk) i_sample_valid <= 1'b1;
    i_sample <= d;
    @(posedge i_mclk) i_sample_valid <= 1'b0;
    cyc(3);
    chk({15'h0, o_input_on, o_reading}, {15'h0, on, rd});
  endtask : samp
  // ==========================================================================
  // answer watcher and hang guard
  // ==========================================================================
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
    if (o_rsp_valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 17'h1ffff;
      chk({o_rsp_exception, e[16] ? 16'h0 : o_rsp_data}, {e[16], e[16] ? 16'h0 : e[15:0]});
    end
  end
  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    seed = 32'h4be1;
    {i_rst_n, i_count_pin, i_sample_valid, i_power_up, i_sample} = '0;
    {i_battery_mv, i_charge_ma, i_supply_mv, i_board_temp} = '0;
    cyc(2);
    chk(o_charge_from_supply, 1);
    @(posedge i_mclk) i_rst_n <= 1'b1;
    for (k = 0; k < 7; k++) acc(0, RA[k], 0, {1'b0, RV[k]});
    for (k = 0; k < 4; k++) begin
      // random battery levels stay above the no-battery limit
      @(posedge i_mclk) i_battery_mv <= (k < 2) ? 16'(4999 + k) : {1'b1, 15'($random(seed))};
      {i_charge_ma, i_supply_mv, i_board_temp} <= 48'({$random(seed), $random(seed)});
      cyc(2);
      chk(o_battery_absent, k == 0);
      chk(o_charge_enable, i_supply_mv > i_battery_mv);
      chk(o_battery_powers, i_supply_mv < i_battery_mv);
      acc(0, A_BATT_MV + k, 0, {1'b0, k == 0 ? i_battery_mv : k == 1 ? i_charge_ma : k == 2 ? i_supply_mv
        : i_board_temp});
    end
    acc(1, A_SUPPLY_MV, 16'h1234, 17'h10000);
    acc(0, 16'h0000, 0, 17'h10000);
    host_u.req(8'hc9, 0, A_SP1_EN, 0);
    for (k = 0; k < 9; k++) acc(1, A_IN_KIND, k, {1'b0, 16'(k)});
    acc(1, A_CHG_ALGO, 0, 0);
    chk(o_charge_from_supply, 0);
    acc(1, A_RISE_EN, 1, 1);
    acc(1, A_FALL_EN, 0, 0);
    acc(1, A_CNT_HIGH, 16'hffff, 17'h0ffff);
    acc(1, A_CNT_LOW, 16'hffff, 17'h0ffff);
    chk(o_count, 32'hffffffff);
    pin(1, 0);
    pin(0, 0);
    acc(1, A_RISE_EN, 0, 0);
    acc(1, A_FALL_EN, 1, 1);
    pin(1, 0);
    pin(0, 1);
    acc(1, A_CNT_LOW, 0, 0);
    acc(1, A_CNT_HIGH, 0, 0);
    chk(o_count, 0);
    acc(1, A_IN_KIND, 3, 3);
    acc(1, A_THRESH, 5000, 5000);
    acc(1, A_HYST, 1500, 1500);
    samp(5000, 5000, 1);
    samp(3501, 3501, 1);
    samp(3500, 3500, 0);
    acc(1, A_FULL_SCL, 1, 1);
    samp(10000, 16'hffff, 1);
    acc(1, A_IN_KIND, 2, 2);
    samp(20000, 16'hffff, 1);
    acc(1, A_IN_KIND, 4, 4);
    acc(1, A_TEMP_UNIT, 1, 1);
    samp(16'd250, 16'd770, 0);
    acc(0, A_READING, 0, 17'd770);
    acc(1, A_SP1_OUT, 1, 1);
    chk(o_pwr1_on, 1);
    acc(1, A_SP1_EN, 0, 0);
    chk(o_pwr1_on, 0);
    acc(1, A_SP1_EN, 1, 1);
    acc(1, A_SP1_VOLT, 1, 1);
    chk(o_pwr1_16v, 1);
    acc(1, A_SP2_OUT, 1, 1);
    chk(o_pwr1_16v | o_pwr2_16v, 0);
    acc(1, A_SP2_OUT, 0, 0);
    acc(1, A_SP2_CONT, 1, 1);
    chk(o_pwr2_on, 0);
    @(posedge i_mclk) i_power_up <= 1'b1;
    @(posedge i_mclk) i_power_up <= 1'b0;
    cyc(2);
    chk(o_pwr2_on, 1);
    cyc(3);
    chk(exp_q.size(), 0);
    report_and_stop();
  end
endmodule : test_iop_regs
